// ### logic/bank_switch_ctrl.sv
/*
 Bank-switch and bus-keeper controller: AHB-Lite slave for the control
 register, idle-cycle insertion on external reads, output clock divider
 control, acknowledge gating and bus keeper enables.
 Assumes the core presents one external access per output-clock period
 and honours the stall output before issuing the next one.
*/
// Our own choice: the AHB-Lite interface to the registers.
// Notes on behaviour
// - One idle cycle on 32K bank crossing
// - Bit 15 clear: idle only on bank, space or page change
// - Bit 15 set: every read three cycles
// - Bits 14-13 divide output clock by N+1
// - Bit 12 set at reset gates acknowledge
// - Bit 2 enables host data keeper
// - Bit 1 enables external data keeper
// - Record address bit 15 (bank bit) of accesses
// - Mismatch: strobe held off one period
// - Record updated each non-I/O access; match normal
// - Same bank adds none; different adds one
// - Program/data space change adds one cycle
// - Program page change adds one cycle
// - Address keeper needs wide pin and bit
// - Wide pin forces host data keeper on
`timescale 1ns/1ps
module bank_switch_ctrl #(
    parameter int PAGE_W = 7
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire bank_switch_pkg::ext_req_s ext_req,
    output logic ext_stall,
    output logic memory_strobe,
    output logic [bank_switch_pkg::addr_w-1:0] ext_addr,
    output logic divided_clock_pin,
    input wire logic irq_ack_core,
    output logic interrupt_ack_pin,
    input wire logic host_port_wide_select,
    output bank_switch_pkg::keeper_s keepers
);
    import bank_switch_pkg::*;

    localparam int bank_bit = $clog2(bank_words);

    typedef enum logic [1:0] {
        st_idle,
        st_start,
        st_read,
        st_trail
    } phase_e;

    logic [15:0] bank_switch_control_q;
    logic wr_pend_q;
    logic rd_pend_q;
    logic [31:0] hrdata_q;
    logic addr_hit;
    logic back_to_back_switch_mode;
    logic [1:0] clock_output_divider;
    logic irq_ack_output_off;
    logic host_bus_keeper_en;
    logic data_bus_keeper_en;
    logic period_tick;
    phase_e phase_q;
    phase_e phase_d;
    logic last_msb_q;
    space_e last_space_q;
    logic [PAGE_W-1:0] last_page_q;
    logic seen_q;
    logic [addr_w-1:0] addr_q;
    logic req_msb;
    logic [PAGE_W-1:0] req_page;
    logic need_gap;
    logic strobe_q;

    assign back_to_back_switch_mode = bank_switch_control_q[mode_bit];
    assign clock_output_divider = bank_switch_control_q[div_hi:div_lo];
    assign irq_ack_output_off = bank_switch_control_q[ack_off_bit];
    assign host_bus_keeper_en = bank_switch_control_q[host_keep_bit];
    assign data_bus_keeper_en = bank_switch_control_q[data_keep_bit];

    // Bus slave: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign addr_hit = (haddr[11:0] == ctrl_addr);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
        end else if (hready) begin
            wr_pend_q <= hsel && htrans[1] && hwrite && addr_hit;
            rd_pend_q <= hsel && htrans[1] && !hwrite && addr_hit;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bank_switch_control_q <= ctrl_reset;
        end else if (wr_pend_q) begin
            bank_switch_control_q <= hwdata[15:0] & ctrl_wmask;
        end
    end

    // Read data registered at the address phase; unmapped reads give zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= '0;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            if (addr_hit) begin
                hrdata_q <= {16'h0000, bank_switch_control_q};
            end else begin
                hrdata_q <= '0;
            end
        end
    end

    clock_divider #(
        .W(2)
    ) u_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .div_sel(clock_output_divider),
        .clk_out(divided_clock_pin),
        .period_tick(period_tick)
    );

    // First bit above the 32K-word bank offset
    assign req_msb = ext_req.addr[bank_bit];
    assign req_page = ext_req.addr[addr_w-1 -: PAGE_W];

    // Gap needed before this read: mode, bank, space or program page change
    always_comb begin
        need_gap = 1'b0;
        if (back_to_back_switch_mode) begin
            need_gap = 1'b1;
        end else if (seen_q) begin
            if (req_msb != last_msb_q) begin
                need_gap = 1'b1;
            end else if (ext_req.space != last_space_q) begin
                need_gap = 1'b1;
            end else if (ext_req.space == space_prog &&
                         req_page != last_page_q) begin
                need_gap = 1'b1;
            end
        end
    end

    always_comb begin
        phase_d = phase_q;
        case (phase_q)
            st_idle: begin
                if (ext_req.valid && ext_req.read) begin
                    phase_d = need_gap ? st_start : st_read;
                end
            end
            st_start: phase_d = st_read;
            st_read: begin
                phase_d = back_to_back_switch_mode ? st_trail : st_idle;
            end
            st_trail: phase_d = st_idle;
            default: phase_d = st_idle;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_q <= st_idle;
        end else if (period_tick) begin
            phase_q <= phase_d;
        end
    end

    // Stall the core while a read sequence is pending
    assign ext_stall = (phase_q != st_idle) ||
                       (ext_req.valid && ext_req.read);

    // Record last program/data access; I/O space leaves it alone
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seen_q <= 1'b0;
            last_msb_q <= 1'b0;
            last_space_q <= space_prog;
            last_page_q <= '0;
            addr_q <= '0;
        end else if (period_tick && phase_q == st_idle && ext_req.valid) begin
            addr_q <= ext_req.addr;
            if (ext_req.space != space_io) begin
                seen_q <= 1'b1;
                last_msb_q <= req_msb;
                last_space_q <= ext_req.space;
                last_page_q <= req_page;
            end
        end
    end

    // Address moves during the start cycle; strobe only in read phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strobe_q <= 1'b0;
        end else if (period_tick) begin
            strobe_q <= (phase_d == st_read) &&
                        !(phase_q == st_idle && phase_d != st_read);
        end
    end

    assign memory_strobe = strobe_q;
    assign ext_addr = addr_q;

    assign interrupt_ack_pin = irq_ack_core && !irq_ack_output_off;

    assign keepers.data_bus = data_bus_keeper_en;
    assign keepers.addr_bus = host_port_wide_select &&
                              host_bus_keeper_en;
    assign keepers.host_data_bus = host_port_wide_select ||
                                   host_bus_keeper_en;

    property p_keep_addr;
        @(posedge hclk) disable iff (!hresetn)
        keepers.addr_bus == (host_port_wide_select && host_bus_keeper_en);
    endproperty
    a_keep_addr: assert property (p_keep_addr)
        else $error("address keeper enable wrong");

    property p_keep_host;
        @(posedge hclk) disable iff (!hresetn)
        host_port_wide_select |-> keepers.host_data_bus;
    endproperty
    a_keep_host: assert property (p_keep_host)
        else $error("host keeper off with wide pin");

    property p_keep_host_bit;
        @(posedge hclk) disable iff (!hresetn)
        !host_port_wide_select |->
            keepers.host_data_bus == host_bus_keeper_en;
    endproperty
    a_keep_host_bit: assert property (p_keep_host_bit)
        else $error("host keeper ignores bit");

    property p_keep_data;
        @(posedge hclk) disable iff (!hresetn)
        keepers.data_bus == bank_switch_control_q[data_keep_bit];
    endproperty
    a_keep_data: assert property (p_keep_data)
        else $error("data keeper enable wrong");

    property p_ack_off;
        @(posedge hclk) disable iff (!hresetn)
        irq_ack_output_off |-> !interrupt_ack_pin;
    endproperty
    a_ack_off: assert property (p_ack_off)
        else $error("acknowledge not gated");

    property p_rsvd;
        @(posedge hclk) disable iff (!hresetn)
        (bank_switch_control_q & ~ctrl_wmask) == 16'h0000;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bit set");

    property p_back_to_back_switch_mode_trail;
        @(posedge hclk) disable iff (!hresetn)
        (period_tick && phase_q == st_read && back_to_back_switch_mode)
            |=> phase_q == st_trail;
    endproperty
    a_back_to_back_switch_mode_trail: assert property (p_back_to_back_switch_mode_trail)
        else $error("no trailing cycle in back-to-back mode");

    property p_start_read;
        @(posedge hclk) disable iff (!hresetn)
        (period_tick && phase_q == st_start) |=> phase_q == st_read;
    endproperty
    a_start_read: assert property (p_start_read)
        else $error("start cycle not followed by read");

    property p_bank_gap;
        @(posedge hclk) disable iff (!hresetn)
        (period_tick && phase_q == st_idle && ext_req.valid &&
         ext_req.read && seen_q && !back_to_back_switch_mode &&
         req_msb != last_msb_q) |=> phase_q == st_start && !memory_strobe;
    endproperty
    a_bank_gap: assert property (p_bank_gap)
        else $error("bank change without idle cycle");

    property p_same_bank;
        @(posedge hclk) disable iff (!hresetn)
        (period_tick && phase_q == st_idle && ext_req.valid &&
         ext_req.read && seen_q && !back_to_back_switch_mode &&
         req_msb == last_msb_q && ext_req.space == last_space_q &&
         (ext_req.space != space_prog || req_page == last_page_q))
            |=> phase_q == st_read && memory_strobe;
    endproperty
    a_same_bank: assert property (p_same_bank)
        else $error("extra cycle on same bank");

    c_gap: cover property (@(posedge hclk) disable iff (!hresetn)
        phase_q == st_start);
    c_trail: cover property (@(posedge hclk) disable iff (!hresetn)
        phase_q == st_trail);
    c_fast: cover property (@(posedge hclk) disable iff (!hresetn)
        phase_q == st_read && !back_to_back_switch_mode);
    c_write: cover property (@(posedge hclk) disable iff (!hresetn)
        wr_pend_q);
endmodule : bank_switch_ctrl

// ### logic/bank_switch_pkg.sv
/*
 Package for the bank-switch and bus-keeper controller: register offset,
 field positions, reset values, bus constants and the carrier structs.
 Assumes a 32-bit AHB-Lite register bus and a 250 MHz processor clock.
*/
package bank_switch_pkg;
    localparam logic [7:0] ctrl_index = 8'h29;
    localparam logic [11:0] ctrl_addr = {2'b00, ctrl_index, 2'b00};
    localparam int mode_bit = 15;
    localparam int div_lo = 13;
    localparam int div_hi = 14;
    localparam int ack_off_bit = 12;
    localparam int host_keep_bit = 2;
    localparam int data_keep_bit = 1;
    localparam logic [15:0] ctrl_reset = 16'hf000;
    localparam logic [15:0] ctrl_wmask = 16'hf006;
    localparam int bank_words = 32768;
    localparam int addr_w = 23;
    localparam logic [1:0] htrans_nonseq = 2'b10;
    localparam logic [1:0] htrans_seq = 2'b11;

    typedef enum logic [1:0] {
        space_prog,
        space_data,
        space_io
    } space_e;

    // One external access request from the core
    typedef struct packed {
        logic valid;
        logic read;
        space_e space;
        logic [addr_w-1:0] addr;
    } ext_req_s;

    // Keeper enables toward the pad ring
    typedef struct packed {
        logic data_bus;
        logic addr_bus;
        logic host_data_bus;
    } keeper_s;
endpackage : bank_switch_pkg

// ### logic/clock_divider.sv
/*
 Output clock divider: produces a divided clock and a one-cycle tick at
 the start of each output period. Assumes divide value stable or changed
 only between periods; a new value takes effect at the next wrap.
 Divide by one forwards the input clock itself to the output.
*/
`timescale 1ns/1ps
module clock_divider #(
    parameter int W = 2
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [W-1:0] div_sel,
    output logic clk_out,
    output logic period_tick
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] sel_q;
    logic [W-1:0] half;
    logic clk_q;

    assign half = W'(({1'b0, sel_q} + 1'b1) >> 1);
    assign period_tick = (cnt_q == '0);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= '0;
            sel_q <= '1;
        end else if (cnt_q == sel_q) begin
            cnt_q <= '0;
            sel_q <= div_sel;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // A flop cannot toggle at the input rate, so divide by one bypasses it
    assign clk_out = (sel_q == '0) ? hclk : clk_q;

    // High at every wrap, so switching to or from bypass cannot glitch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_q <= 1'b1;
        end else begin
            clk_q <= (cnt_q == sel_q) || (W'(cnt_q + 1'b1) < half);
        end
    end
endmodule : clock_divider

// ### verification/ext_mem_model.sv
/*
 Passive model of the external memory banks: counts cycles in which the
 read strobe is high and keeps the address seen while it was high.
 Assumes the strobe is sampled on the processor clock.
*/
`timescale 1ns/1ps
module ext_mem_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic memory_strobe,
    input wire logic [bank_switch_pkg::addr_w-1:0] ext_addr,
    output int strobe_cycles,
    output logic [bank_switch_pkg::addr_w-1:0] read_addr
);
    import bank_switch_pkg::*;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strobe_cycles <= 0;
            read_addr <= '0;
        end else if (memory_strobe) begin
            strobe_cycles <= strobe_cycles + 1;
            read_addr <= ext_addr;
        end
    end
endmodule : ext_mem_model

// ### verification/testbench.sv
/*
 Self-checking bench for bank_switch_ctrl: register access, keepers,
 acknowledge gating, clock divide and read gap insertion.
 Assumes single word AHB-Lite transfers and a 4 ns clock.
*/
`timescale 1ns/1ps
module testbench;
    import bank_switch_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic irq_ack_core = 1'b1;
    logic host_port_wide_select = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, ext_stall, memory_strobe, divided_clock_pin;
    logic interrupt_ack_pin;
    logic [addr_w-1:0] ext_addr, read_addr;
    ext_req_s ext_req = '0;
    keeper_s keepers;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int strobe_cycles;

    bank_switch_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .ext_req(ext_req),
        .ext_stall(ext_stall), .memory_strobe(memory_strobe),
        .ext_addr(ext_addr), .divided_clock_pin(divided_clock_pin),
        .irq_ack_core(irq_ack_core), .interrupt_ack_pin(interrupt_ack_pin),
        .host_port_wide_select(host_port_wide_select), .keepers(keepers));

    ext_mem_model mem (.hclk(hclk), .hresetn(hresetn),
        .memory_strobe(memory_strobe), .ext_addr(ext_addr),
        .strobe_cycles(strobe_cycles), .read_addr(read_addr));

    initial forever #2 hclk = ~hclk;

    task finish_test;
        $display("mismatches %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test

    // Generous ceiling; the full run needs well under 2000 cycles
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            $display("unexpected at %0t: bench hung", $time);
            finish_test();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= htrans_nonseq;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb

    task reg_io;
        ahb(1'b0, 32'(ctrl_addr), 32'h0);
        chk(rd, 32'h0000f000);
        chk({31'h0, hresp}, 32'h0);
        chk({31'h0, interrupt_ack_pin}, 32'h0);
        ahb(1'b1, 32'(ctrl_addr), 32'hffffffff);
        ahb(1'b0, 32'(ctrl_addr), 32'h0);
        chk(rd, 32'h0000f006);
        // Unmapped neighbour must neither answer nor alias
        ahb(1'b1, 32'h0a8, 32'h0);
        ahb(1'b0, 32'h0a8, 32'h0);
        chk(rd, 32'h0);
        ahb(1'b0, 32'(ctrl_addr), 32'h0);
        chk(rd, 32'h0000f006);
        ahb(1'b1, 32'(ctrl_addr), 32'h0);
        #1 chk({31'h0, interrupt_ack_pin}, 32'h1);
        irq_ack_core <= 1'b0;
        #1 chk({31'h0, interrupt_ack_pin}, 32'h0);
    endtask : reg_io

    task keeper_table;
        logic [2:0] want;
        for (int i = 0; i < 8; i++) begin
            host_port_wide_select <= i[2];
            ahb(1'b1, 32'(ctrl_addr), 32'({4'h1, 9'h0, i[0], i[1], 1'b0}));
            want = {i[1], i[2] & i[0], i[2] | i[0]};
            #1 chk({29'h0, keepers}, {29'h0, want});
        end
    endtask : keeper_table

    task divider;
        realtime t0;
        for (int d = 0; d < 4; d++) begin
            ahb(1'b1, 32'(ctrl_addr), 32'({1'b0, d[1:0], 1'b1, 12'h0}));
            repeat (2) @(posedge divided_clock_pin);
            t0 = $realtime;
            @(posedge divided_clock_pin);
            chk(32'(int'(($realtime - t0) / 4.0)), 32'(d + 1));
        end
    endtask : divider

    task ext_read(input space_e sp, input logic [22:0] a, input int lat);
        int n;
        int s0;
        @(posedge hclk);
        s0 = strobe_cycles;
        ext_req <= '{valid: 1'b1, read: 1'b1, space: sp, addr: a};
        @(posedge hclk);
        ext_req.valid <= 1'b0;
        n = 1;
        #1;
        while (memory_strobe !== 1'b1 && n < 20) begin
            @(posedge hclk);
            #1;
            n++;
        end
        chk(32'(n), 32'(lat));
        while (ext_stall !== 1'b0) @(posedge hclk);
        repeat (2) @(posedge hclk);
        chk(32'(read_addr), 32'(a));
        chk(32'(strobe_cycles - s0), 32'h1);
    endtask : ext_read

    task bank_reads;
        ahb(1'b1, 32'(ctrl_addr), 32'h00001000);
        repeat (8) @(posedge hclk);
        ext_read(space_prog, 23'h000000, 1);
        ext_read(space_prog, 23'h000100, 1);
        ext_read(space_prog, 23'h008000, 2);
        ext_read(space_prog, 23'h00c000, 1);
        ext_read(space_prog, 23'h018000, 2);
        ext_read(space_data, 23'h018000, 2);
        ext_read(space_data, 23'h018004, 1);
        ext_read(space_prog, 23'h018008, 2);
        // I/O reads must leave the recorded bank and space alone
        ext_read(space_io, 23'h000000, 2);
        ext_read(space_prog, 23'h01800c, 1);
        ahb(1'b1, 32'(ctrl_addr), 32'h00009000);
        ext_read(space_prog, 23'h01800c, 2);
        ext_read(space_prog, 23'h018010, 2);
    endtask : bank_reads

    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        reg_io();
        keeper_table();
        divider();
        bank_reads();
        finish_test();
    end
endmodule : testbench
